// >>> output_mux_volume_control.sv
// output source muxes and headphone level control with staged update
// Behaviour
// R1: left headphone source: 0 DAC, 1 bypass
// R2: right headphone source: 0 DAC, 1 bypass
// R3: left line source: 0 DAC, 1 bypass
// R4: right line source: 0 DAC, 1 bypass
// R5: reset clears all four source selects
// R6: level code 1 dB steps, -57 to +6
// R7: reset levels 10_1101, mute/update/zc zero
// R8: per-channel mute bit 8 silences channel
// R9: write without update bit only stores level
// R10: update bit in either register commits both
// R11: zero-cross enabled defers change until crossing
// R12: timeout applies deferred change if clock enabled
// R13: zero-cross disabled applies change immediately
`timescale 1ns/1ns
module output_mux_volume_control
  import out_mux_pkg::*;
#(
  parameter int timeout_count = timeout_cycles // zero-cross wait limit
)
(
  input  wire logic        ref_clk,             // 20 MHz block clock
  input  wire logic        rst_n,               // async reset, active low
  input  wire logic        psel,                // apb select
  input  wire logic        penable,             // apb access phase
  input  wire logic        pwrite,              // apb direction
  input  wire logic [11:0] paddr,               // apb byte address
  input  wire logic [31:0] pwdata,              // apb write data
  output logic      [31:0] prdata,              // apb read data
  output logic             pready,              // apb ready
  output logic             pslverr,             // apb error
  input  wire logic        hp_left_zero_hit,    // left signal crossed zero
  input  wire logic        hp_right_zero_hit,   // right signal crossed zero
  output logic             hp_left_source_bypass,    // hp left mux select
  output logic             hp_right_source_bypass,   // hp right mux select
  output logic             line_left_source_bypass,  // line left mux select
  output logic             line_right_source_bypass, // line right mux select
  output logic      [5:0]  hp_left_level,       // applied left gain code
  output logic      [5:0]  hp_right_level,      // applied right gain code
  output logic             hp_left_silence,     // left channel muted
  output logic             hp_right_silence     // right channel muted
);

  // reset release through two flops
  logic        rst_meta;                        // first sync stage
  logic        rst_sync_n;                      // design-wide reset

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_meta   <= 1'b0;
      rst_sync_n <= 1'b0;
    end
    else
    begin
      rst_meta   <= 1'b1;
      rst_sync_n <= rst_meta;
    end
  end

  // register storage
  hp_chan_t    stored_left;                     // staged left settings
  hp_chan_t    stored_right;                    // staged right settings
  logic [3:0]  source_sel;                      // four mux selects
  logic        timeout_clock_en;                // timeout clock enable
  upd_state_t  state_left;                      // left update state
  upd_state_t  state_right;                     // right update state
  logic [cnt_w-1:0] wait_left;                  // left timeout counter
  logic [cnt_w-1:0] wait_right;                 // right timeout counter

  // apb decode: one wait state, answer in the second access cycle
  function automatic logic hit(input logic [11:0] a, input logic [11:0] r);
    return a == r;
  endfunction

  wire         access      = psel & penable;
  wire         wr          = access & pwrite;
  wire         wr_left     = wr & hit(paddr, addr_hp_left);
  wire         wr_right    = wr & hit(paddr, addr_hp_right);
  wire         wr_source   = wr & hit(paddr, addr_source_select);
  wire         wr_timeout  = wr & hit(paddr, addr_timeout_ctrl);
  wire         mapped      = hit(paddr, addr_hp_left)
                           | hit(paddr, addr_hp_right)
                           | hit(paddr, addr_source_select)
                           | hit(paddr, addr_timeout_ctrl)
                           | hit(paddr, addr_applied_status);
  // the commit bit is write-only: it never stores, it only fires
  wire         commit      = (wr_left | wr_right)
                           & pwdata[bit_commit];            // [R10]

  // incoming channel value from write data
  wire hp_chan_t wdata_chan = '{silence:       pwdata[bit_silence],
                                zero_cross_en: pwdata[bit_zero_cross],
                                level:         pwdata[5:0]};

  // read mux: level registers read back stored, not applied, values
  logic [31:0] next_prdata;                     // read data for this access
  always_comb
  begin
    next_prdata = 32'h0000_0000;
    if (hit(paddr, addr_hp_left))
      next_prdata = {23'h0, stored_left.silence, 1'b0,
                     stored_left.zero_cross_en, stored_left.level};
    else if (hit(paddr, addr_hp_right))
      next_prdata = {23'h0, stored_right.silence, 1'b0,
                     stored_right.zero_cross_en, stored_right.level};
    else if (hit(paddr, addr_source_select))
      next_prdata = {28'h0, source_sel};
    else if (hit(paddr, addr_timeout_ctrl))
      next_prdata = {31'h0, timeout_clock_en};
    else if (hit(paddr, addr_applied_status))
      next_prdata = {16'h0, state_right == st_pending,
                     state_left == st_pending, hp_right_level,
                     2'h0, hp_left_level};
  end

  // apb answer flops: pready pulses one cycle after the access starts
  always_ff @(posedge ref_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end
    else
    begin
      pready  <= access & ~pready;
      pslverr <= access & ~pready & ~mapped;
      prdata  <= (access & ~pready & ~pwrite) ? next_prdata : 32'h0000_0000;
    end
  end

  // writes only take effect on the completing edge
  wire         done        = access & pready;

  // stored settings and mux selects
  always_ff @(posedge ref_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      stored_left      <= '{silence: 1'b0, zero_cross_en: 1'b0,
                            level: level_reset};            // [R7]
      stored_right     <= '{silence: 1'b0, zero_cross_en: 1'b0,
                            level: level_reset};            // [R7]
      source_sel       <= source_reset;                     // [R5]
      timeout_clock_en <= 1'b0;
    end
    else
    begin
      if (wr_left & done)
        stored_left <= wdata_chan;                          // [R9]
      if (wr_right & done)
        stored_right <= wdata_chan;                         // [R9]
      if (wr_source & done)
        source_sel <= pwdata[3:0];
      if (wr_timeout & done)
        timeout_clock_en <= pwdata[bit_timeout_en];
    end
  end

  // mux select outputs straight from flops
  always_ff @(posedge ref_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      hp_left_source_bypass    <= 1'b0;
      hp_right_source_bypass   <= 1'b0;
      line_left_source_bypass  <= 1'b0;
      line_right_source_bypass <= 1'b0;
    end
    else
    begin
      hp_left_source_bypass    <= source_sel[bit_hp_left_byp];    // [R1]
      hp_right_source_bypass   <= source_sel[bit_hp_right_byp];   // [R2]
      line_left_source_bypass  <= source_sel[bit_line_left_byp];  // [R3]
      line_right_source_bypass <= source_sel[bit_line_right_byp]; // [R4]
    end
  end

  // mute follows the stored bit at once; it is not staged
  always_ff @(posedge ref_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      hp_left_silence  <= 1'b0;
      hp_right_silence <= 1'b0;
    end
    else
    begin
      hp_left_silence  <= stored_left.silence;              // [R8]
      hp_right_silence <= stored_right.silence;             // [R8]
    end
  end

  // the commit edge: stored values still hold the old setting because commit and store
  // share the completing edge, so apply uses the write data directly
  wire         fire        = commit & done;
  wire [5:0]   new_left    = wr_left  ? pwdata[5:0] : stored_left.level;
  wire [5:0]   new_right   = wr_right ? pwdata[5:0] : stored_right.level;
  wire         zc_left     = wr_left  ? pwdata[bit_zero_cross]
                                      : stored_left.zero_cross_en;
  wire         zc_right    = wr_right ? pwdata[bit_zero_cross]
                                      : stored_right.zero_cross_en;
  wire         tmo_left    = timeout_clock_en
                           & (wait_left  >= cnt_w'(timeout_count - 1));
  wire         tmo_right   = timeout_clock_en
                           & (wait_right >= cnt_w'(timeout_count - 1));

  // per-channel apply logic, identical for both sides
  always_ff @(posedge ref_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      hp_left_level <= level_reset;                         // [R7]
      state_left    <= st_idle;
      wait_left     <= '0;
    end
    else if (fire)
    begin
      wait_left <= '0;
      if (zc_left)
        state_left <= st_pending;                           // [R11]
      else
      begin
        hp_left_level <= new_left;                          // [R13]
        state_left    <= st_idle;
      end
    end
    else
    begin
      unique case (state_left)
        st_idle:
          wait_left <= '0;
        st_pending:
        begin
          // zero crossing wins; timeout only counts with its clock enabled
          if (hp_left_zero_hit | tmo_left)                  // [R11] [R12]
          begin
            hp_left_level <= stored_left.level;             // [R6]
            state_left    <= st_idle;
          end
          else if (timeout_clock_en)
            wait_left <= wait_left + 1'b1;                  // [R12]
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      hp_right_level <= level_reset;                        // [R7]
      state_right    <= st_idle;
      wait_right     <= '0;
    end
    else if (fire)
    begin
      wait_right <= '0;
      if (zc_right)
        state_right <= st_pending;                          // [R11]
      else
      begin
        hp_right_level <= new_right;                        // [R13]
        state_right    <= st_idle;
      end
    end
    else
    begin
      unique case (state_right)
        st_idle:
          wait_right <= '0;
        st_pending:
        begin
          if (hp_right_zero_hit | tmo_right)                // [R11] [R12]
          begin
            hp_right_level <= stored_right.level;           // [R6]
            state_right    <= st_idle;
          end
          else if (timeout_clock_en)
            wait_right <= wait_right + 1'b1;                // [R12]
        end
      endcase
    end
  end

endmodule

// >>> out_mux_pkg.sv
// package: register map, field layout and reset values of the output mux block
package out_mux_pkg;
  // register indices (word numbers, not byte addresses, so byte addr = 4*idx)
  localparam logic [7:0]  idx_hp_left         = 8'h39;
  localparam logic [7:0]  idx_hp_right        = 8'h3A;
  localparam logic [7:0]  idx_source_select   = 8'h3D;
  localparam logic [7:0]  idx_timeout_ctrl    = 8'h40;
  localparam logic [7:0]  idx_applied_status  = 8'h41;
  localparam logic [11:0] addr_hp_left        = {2'h0, idx_hp_left, 2'h0};
  localparam logic [11:0] addr_hp_right       = {2'h0, idx_hp_right, 2'h0};
  localparam logic [11:0] addr_source_select  = {2'h0, idx_source_select, 2'h0};
  localparam logic [11:0] addr_timeout_ctrl   = {2'h0, idx_timeout_ctrl, 2'h0};
  localparam logic [11:0] addr_applied_status = {2'h0, idx_applied_status, 2'h0};
  // field positions in a headphone level register
  localparam int          bit_silence         = 8;
  localparam int          bit_commit          = 7;
  localparam int          bit_zero_cross      = 6;
  // field positions in the source select and timeout control registers
  localparam int          bit_hp_left_byp     = 3;
  localparam int          bit_hp_right_byp    = 2;
  localparam int          bit_line_left_byp   = 1;
  localparam int          bit_line_right_byp  = 0;
  localparam int          bit_timeout_en      = 0;
  // reset values
  localparam logic [5:0]  level_reset         = 6'h2D;
  localparam logic [3:0]  source_reset        = 4'h0;
  // zero-cross timeout: given as a time in microseconds
  localparam int          clk_hz              = 20_000_000;
  localparam int          timeout_us          = 10_000;
  localparam int          timeout_cycles      = timeout_us * (clk_hz / 1_000_000);
  localparam int          cnt_w               = 20;
  // one headphone channel: stored settings
  typedef struct packed
  {
    logic       silence;
    logic       zero_cross_en;
    logic [5:0] level;
  } hp_chan_t;
  // state of the deferred update for one channel
  typedef enum logic [1:0]
  {
    st_idle    = 2'b01,
    st_pending = 2'b10
  } upd_state_t;
endpackage

// >>> output_mux_volume_control_asserts.sv
// checker: port timing relations of the output mux block
`timescale 1ns/1ns
module output_mux_volume_control_asserts
  import out_mux_pkg::*;
#(
  parameter int timeout_count = 8 // zero-cross wait limit
)
(
  input wire logic        ref_clk,                  // clock
  input wire logic        rst_n,                    // reset
  input wire logic        psel,                     // select
  input wire logic        penable,                  // access
  input wire logic        pwrite,                   // direction
  input wire logic [11:0] paddr,                    // address
  input wire logic [31:0] pwdata,                   // write data
  input wire logic        pready,                   // ready
  input wire logic        hp_left_zero_hit,         // left crossing
  input wire logic        hp_left_source_bypass,    // mux select
  input wire logic        hp_right_source_bypass,   // mux select
  input wire logic        line_left_source_bypass,  // mux select
  input wire logic        line_right_source_bypass, // mux select
  input wire logic [5:0]  hp_left_level,            // applied left
  input wire logic [5:0]  hp_right_level,           // applied right
  input wire logic        hp_left_silence,          // left mute
  input wire logic        hp_right_silence          // right mute
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);
  // completed writes; commit means update bit set with zero-cross off
  wire       wr_done  = psel && penable && pready && pwrite;
  wire       wr_left  = wr_done && paddr == addr_hp_left;
  wire       wr_right = wr_done && paddr == addr_hp_right;
  wire       commit   = pwdata[bit_commit] && !pwdata[bit_zero_cross];
  wire [3:0] srcs     = {hp_left_source_bypass, hp_right_source_bypass,
                         line_left_source_bypass, line_right_source_bypass};
  property p_hold;
    (wr_left || wr_right) && !pwdata[bit_commit] && !hp_left_zero_hit
      |=> $stable(hp_left_level);
  endproperty
  a_hold: assert property (p_hold)
    else $error("left gain moved without commit");
  property p_commit_left;
    wr_left && commit |=> hp_left_level == $past(pwdata[5:0]);
  endproperty
  a_commit_left: assert property (p_commit_left)
    else $error("left gain not applied");
  property p_commit_right;
    wr_right && commit |=> hp_right_level == $past(pwdata[5:0]);
  endproperty
  a_commit_right: assert property (p_commit_right)
    else $error("right gain not applied");
  // zero-cross armed: the level is checked to hold on the first edge after the commit;
  // a crossing in the cycle after the commit may move it one edge later
  property p_defer;
    wr_left && pwdata[bit_commit] && pwdata[bit_zero_cross] &&
      !hp_left_zero_hit |=> $stable(hp_left_level) ##1
      ($stable(hp_left_level) || $past(hp_left_zero_hit));
  endproperty
  a_defer: assert property (p_defer)
    else $error("deferred gain applied early");
  property p_mute;
    wr_left |-> ##2 hp_left_silence == $past(pwdata[bit_silence], 2);
  endproperty
  a_mute: assert property (p_mute)
    else $error("left mute does not follow write");
  property p_sources;
    wr_done && paddr == addr_source_select
      |-> ##2 srcs == $past(pwdata[3:0], 2);
  endproperty
  a_sources: assert property (p_sources)
    else $error("mux selects do not follow write");
  property p_reset_state;
    $rose(rst_n) |-> hp_left_level == level_reset && !hp_left_silence &&
      hp_right_level == level_reset && !hp_right_silence;
  endproperty
  a_reset_state: assert property (p_reset_state)
    else $error("headphone state wrong after reset");
  property p_reset_sources;
    $rose(rst_n) |-> srcs == source_reset;
  endproperty
  a_reset_sources: assert property (p_reset_sources)
    else $error("mux selects wrong after reset");
  c_crossing: cover property (hp_left_zero_hit ##1 $changed(hp_left_level));
  c_select: cover property (wr_done && paddr == addr_source_select);
  c_commit: cover property (wr_right && commit);
endmodule
bind output_mux_volume_control output_mux_volume_control_asserts
  #(.timeout_count(timeout_count)) u_chk (
  .ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .hp_left_zero_hit(hp_left_zero_hit),
  .hp_left_source_bypass(hp_left_source_bypass),
  .hp_right_source_bypass(hp_right_source_bypass),
  .line_left_source_bypass(line_left_source_bypass),
  .line_right_source_bypass(line_right_source_bypass),
  .hp_left_level(hp_left_level), .hp_right_level(hp_right_level),
  .hp_left_silence(hp_left_silence), .hp_right_silence(hp_right_silence));

// >>> test_output_mux_volume_control.sv
// testbench: APB register tests of the output mux block
`timescale 1ns/1ns
module test_output_mux_volume_control;
  import out_mux_pkg::*;
  localparam int tmo = 8;                     // short zero-cross wait
  logic        ref_clk, rst_n, err;           // clock, reset, last error
  logic        psel, penable, pwrite, pready, pslverr; // bus control
  logic [11:0] paddr;                         // bus address
  logic [31:0] pwdata, prdata, rd;            // bus data, last read
  logic        zero_l, zero_r;                // crossing hits
  logic [3:0]  src;                           // mux selects, bit 3 hp left
  logic [5:0]  lvl_l, lvl_r;                  // applied gains
  logic        mute_l, mute_r;                // applied mutes
  int          miscompares, num_checks, cycles; // tallies
  output_mux_volume_control #(.timeout_count(tmo)) uut (
    .ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .hp_left_zero_hit(zero_l),
    .hp_right_zero_hit(zero_r), .hp_left_source_bypass(src[3]),
    .hp_right_source_bypass(src[2]), .line_left_source_bypass(src[1]),
    .line_right_source_bypass(src[0]), .hp_left_level(lvl_l),
    .hp_right_level(lvl_r), .hp_left_silence(mute_l),
    .hp_right_silence(mute_r));
  // 20 MHz clock
  initial
  begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  // verdict and end of run
  task automatic tally_and_finish;
    $display("checks %0d, mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // cycle ceiling: the whole run needs well under 400 cycles
  always @(posedge ref_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 2000)
    begin
      miscompares++;
      tally_and_finish();
    end
  end
  task automatic check(string what, logic [31:0] exp, logic [31:0] got);
    num_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  // one APB transfer held until pready; answer kept in rd and err
  task automatic bus(logic wr, logic [11:0] a, logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do
    begin
      @(posedge ref_clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1)
      check("bus answer", 32'h1, 32'h0);
  endtask
  task automatic rd_chk(string what, logic [11:0] a, logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    check(what, exp, rd);
  endtask
  // mux selects and mutes lag a write by two edges, a committed gain by one; wait past that
  task automatic settle;
    repeat (3) @(posedge ref_clk);
    #1;
  endtask
  initial
  begin
    {rst_n, psel, penable, pwrite, zero_l, zero_r} = 6'h00;
    paddr = 12'h000;
    pwdata = 32'h0;
    miscompares = 0;
    num_checks = 0;
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'b1;
    settle();
    check("reset gains", {level_reset, level_reset}, {lvl_l, lvl_r});
    check("reset selects", 6'h00, {mute_l, mute_r, src});
    rd_chk("left reg", addr_hp_left, 32'h2D);
    $display("reset test done");
    for (int i = 0; i < 4; i++)
    begin
      bus(1'b1, addr_source_select, 32'h1 << i);
      settle();
      check("mux selects", 32'h1 << i, src);
    end
    rd_chk("select reg", addr_source_select, 32'h8);
    $display("source select test done");
    bus(1'b1, addr_hp_left, 32'h000);
    bus(1'b1, addr_hp_right, 32'h03F);
    settle();
    check("held gains", {level_reset, level_reset}, {lvl_l, lvl_r});
    rd_chk("stored left", addr_hp_left, 32'h000);
    bus(1'b1, addr_hp_right, 32'h0BF);
    settle();
    check("committed gains", 12'h03F, {lvl_l, lvl_r});
    $display("staged update test done");
    bus(1'b1, addr_hp_left, 32'h1B9);
    settle();
    check("mutes, gains", 14'h2E7F, {mute_l, mute_r, lvl_l, lvl_r});
    rd_chk("left reg", addr_hp_left, 32'h139);
    bus(1'b1, addr_hp_left, 32'h0C0);
    settle();
    check("deferred left", 6'h39, lvl_l);
    @(posedge ref_clk);
    zero_l <= 1'b1;
    @(posedge ref_clk);
    zero_l <= 1'b0;
    settle();
    check("left at crossing", 6'h00, lvl_l);
    $display("mute and zero-cross test done");
    bus(1'b1, addr_hp_left, 32'h0D5);
    repeat (20) @(posedge ref_clk);
    #1;
    check("left, timeout off", 6'h00, lvl_l);
    bus(1'b1, addr_timeout_ctrl, 32'h1);
    repeat (tmo + 4) @(posedge ref_clk);
    #1;
    check("left after timeout", 6'h15, lvl_l);
    rd_chk("applied status", addr_applied_status, 32'h3F15);
    bus(1'b1, addr_hp_right, 32'h1C5);
    rd_chk("both pending", addr_applied_status, 32'hFF15);
    @(posedge ref_clk);
    zero_r <= 1'b1;
    @(posedge ref_clk);
    zero_r <= 1'b0;
    settle();
    check("right mute, gain", 8'h45, {mute_l, mute_r, lvl_r});
    rd_chk("after crossing", addr_applied_status, 32'h0515);
    bus(1'b0, 12'h000, 32'h0);
    check("unmapped error", 32'h1, {31'h0, err});
    check("unmapped data", 32'h0, rd);
    $display("timeout and unmapped test done");
    tally_and_finish();
  end
endmodule
